//--- verilog/dps_pkg.sv
// Shared constants, types and helpers for both ends of the memory pin link.
`default_nettype none
package dps_pkg;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int BANK_W = 2;
    localparam int DAT_W = 16;
    localparam int LANES = 2;
    localparam int ADDR_W = 12;
    localparam int BEAT_W = 4;
    localparam int AUTO_PRE_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LINK_HALF_CYC = 4;
    localparam int RD_LAT_CYC = 1;
    localparam int SREF_INT_NS = 15625;
    localparam int SREF_INT_CYC = SREF_INT_NS * 1000 / CLK_PERIOD_PS;
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [3:0] PINS_IDLE = 4'hF;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_RESET = BL_CODE_2;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_PDOWN = 2'b01,
        MODE_SREF = 2'b10
    } dps_mode_e;

    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_ACT = 3'b001,
        OP_READ = 3'b010,
        OP_WRITE = 3'b011,
        OP_PRE = 3'b100,
        OP_REF = 3'b101,
        OP_MRS = 3'b110,
        OP_SREF = 3'b111
    } dps_op_e;

    // Beats per burst for a mode code; zero marks an unsupported length.
    function automatic logic [BEAT_W-1:0] dps_bl_beats(input logic [2:0] code);
        if (code >= BL_CODE_2 && code <= BL_CODE_8) begin
            return BEAT_W'(1) << code;
        end
        return '0;
    endfunction

    // Sequential column within the burst-aligned block.
    function automatic logic [COL_W-1:0] dps_burst_col(input logic [COL_W-1:0] base,
        input logic [BEAT_W-1:0] beat, input logic [2:0] code);
        logic [COL_W-1:0] wrapMask;
        wrapMask = COL_W'(dps_bl_beats(code)) - COL_W'(1);
        return (base & ~wrapMask) | ((base + COL_W'(beat)) & wrapMask);
    endfunction

    // Chip select and the three strobes for a user operation.
    function automatic logic [3:0] dps_op_pins(input dps_op_e op);
        case (op)
            OP_ACT: return {1'b0, CMD_ACT};
            OP_READ: return {1'b0, CMD_READ};
            OP_WRITE: return {1'b0, CMD_WRITE};
            OP_PRE: return {1'b0, CMD_PRE};
            OP_REF: return {1'b0, CMD_REF};
            OP_SREF: return {1'b0, CMD_REF};
            OP_MRS: return {1'b0, CMD_MRS};
            default: return PINS_IDLE;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- verilog/dps_link_if.sv
// Pin bundle between the memory device and its controller.
`default_nettype none
interface dps_link_if;
    import dps_pkg::*;
    logic diff_clk_pos;
    logic diff_clk_neg;
    logic clk_gate_in;
    logic chip_sel_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic bank_sel_0;
    logic bank_sel_1;
    logic [ADDR_W-1:0] addr_bus;
    logic wr_mask_lo;
    logic wr_mask_hi;
    logic [DAT_W-1:0] dataDev;
    logic dataDevOe;
    logic [DAT_W-1:0] dataCtl;
    logic dataCtlOe;
    logic [LANES-1:0] strobeDev;
    logic strobeDevOe;
    logic [LANES-1:0] strobeCtl;
    logic strobeCtlOe;
    logic [DAT_W-1:0] data_lines;
    logic strobe_lo;
    logic strobe_hi;

    // Undriven lines settle low, as the termination pulls them there.
    assign data_lines = dataDevOe ? dataDev : (dataCtlOe ? dataCtl : '0);
    assign strobe_lo = strobeDevOe ? strobeDev[0] : (strobeCtlOe ? strobeCtl[0] : 1'b0);
    assign strobe_hi = strobeDevOe ? strobeDev[1] : (strobeCtlOe ? strobeCtl[1] : 1'b0);

    modport dev (
        input diff_clk_pos, diff_clk_neg, clk_gate_in, chip_sel_n, row_strobe_n,
        input col_strobe_n, write_strobe_n, bank_sel_0, bank_sel_1, addr_bus,
        input wr_mask_lo, wr_mask_hi, data_lines, strobe_lo, strobe_hi,
        output dataDev, dataDevOe, strobeDev, strobeDevOe
    );
    modport ctl (
        output diff_clk_pos, diff_clk_neg, clk_gate_in, chip_sel_n, row_strobe_n,
        output col_strobe_n, write_strobe_n, bank_sel_0, bank_sel_1, addr_bus,
        output wr_mask_lo, wr_mask_hi, dataCtl, dataCtlOe, strobeCtl, strobeCtlOe,
        input data_lines, strobe_lo, strobe_hi
    );
endinterface
`default_nettype wire

//--- verilog/dps_device.sv
// Memory device end: command decode, four banks, strobed data and low-power modes.
`default_nettype none
module dps_device #(
    parameter int RD_LAT = dps_pkg::RD_LAT_CYC,
    parameter int SREF_INT = dps_pkg::SREF_INT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    dps_link_if.dev link,
    output logic [1:0] devMode,
    output logic [3:0] bankOpen,
    output logic [dps_pkg::ROW_W-1:0] refreshRow
);
    import dps_pkg::*;

    localparam int MEM_AW = BANK_W + ROW_W + COL_W;

    typedef struct packed {
        logic clkPos;
        logic clkNeg;
        logic gate;
        logic selN;
        logic [2:0] cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [DAT_W-1:0] dat;
        logic [LANES-1:0] stb;
        logic [LANES-1:0] mask;
    } dps_pins_s;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_BURST = 2'b10
    } dps_rd_e;

    typedef struct packed {
        dps_pins_s s1;
        dps_pins_s s2;
        logic clkPrev;
        logic [LANES-1:0] stbPrev;
        logic gatePrev;
        dps_mode_e mode;
        logic [3:0] open;
        logic [3:0][ROW_W-1:0] rows;
        logic [2:0] blCode;
        logic wrOn;
        logic wrAuto;
        logic [BANK_W-1:0] wrBank;
        logic [ROW_W-1:0] wrRow;
        logic [COL_W-1:0] wrCol;
        logic [LANES-1:0][BEAT_W-1:0] wrCnt;
        dps_rd_e rdSt;
        logic [7:0] rdWait;
        logic rdAuto;
        logic [BANK_W-1:0] rdBank;
        logic [ROW_W-1:0] rdRow;
        logic [COL_W-1:0] rdCol;
        logic [BEAT_W-1:0] rdCnt;
        logic [DAT_W-1:0] datOut;
        logic datOe;
        logic stbOut;
        logic stbOe;
        logic [ROW_W-1:0] refRow;
        logic [15:0] srTimer;
    } dps_dev_s;

    dps_dev_s state_reg;
    dps_dev_s state_next;
    logic [DAT_W-1:0] mem [0:(1 << MEM_AW) - 1];
    logic [LANES-1:0] wrLaneEn;
    logic [LANES-1:0][MEM_AW-1:0] wrAddr;
    logic [MEM_AW-1:0] rdAddr;
    logic rise;
    logic fall;
    logic busy;
    logic cmdOk;
    logic [BEAT_W-1:0] blBeats;
    logic [BANK_W-1:0] bank;

    always_comb begin
        state_next = state_reg;
        wrLaneEn = '0;
        wrAddr = '0;
        state_next.s1 = {link.diff_clk_pos, link.diff_clk_neg, link.clk_gate_in,
            link.chip_sel_n, link.row_strobe_n, link.col_strobe_n, link.write_strobe_n,
            link.bank_sel_1, link.bank_sel_0, link.addr_bus, link.data_lines,
            link.strobe_hi, link.strobe_lo, link.wr_mask_hi, link.wr_mask_lo};
        state_next.s2 = state_reg.s1;
        state_next.clkPrev = state_reg.s2.clkPos;
        state_next.stbPrev = state_reg.s2.stb;
        // Edge taken where the pair crosses: positive high, negative low.
        rise = state_reg.s2.clkPos & ~state_reg.s2.clkNeg & ~state_reg.clkPrev;
        fall = ~state_reg.s2.clkPos & state_reg.clkPrev;
        blBeats = dps_bl_beats(state_reg.blCode);
        busy = state_reg.wrOn | (state_reg.rdSt != RD_IDLE);
        bank = state_reg.s2.bank;
        cmdOk = rise & state_reg.gatePrev & state_reg.s2.gate & ~state_reg.s2.selN
            & (state_reg.mode == MODE_RUN);
        rdAddr = {state_reg.rdBank, state_reg.rdRow,
            dps_burst_col(state_reg.rdCol, state_reg.rdCnt, state_reg.blCode)};

        if (rise) begin
            state_next.gatePrev = state_reg.s2.gate;
            if (state_reg.mode != MODE_RUN) begin
                if (state_reg.s2.gate) begin
                    state_next.mode = MODE_RUN;
                end
            end else if (state_reg.gatePrev && !state_reg.s2.gate && !busy) begin
                if (!state_reg.s2.selN && state_reg.s2.cmd == CMD_REF
                    && state_reg.open == '0) begin
                    state_next.mode = MODE_SREF;
                    state_next.refRow = state_reg.refRow + ROW_W'(1);
                end else if (state_reg.s2.selN || state_reg.s2.cmd == CMD_NOP) begin
                    state_next.mode = MODE_PDOWN;
                end
            end
        end

        // The refresh counter keeps stepping while the link clock may be stopped.
        state_next.srTimer = '0;
        if (state_reg.mode == MODE_SREF) begin
            state_next.srTimer = state_reg.srTimer + 16'h0001;
            if (state_reg.srTimer == 16'(SREF_INT - 1)) begin
                state_next.srTimer = '0;
                state_next.refRow = state_reg.refRow + ROW_W'(1);
            end
        end

        case (state_reg.rdSt)
            RD_WAIT: begin
                if (rise) begin
                    state_next.rdWait = state_reg.rdWait - 8'h01;
                    if (state_reg.rdWait == 8'h01) begin
                        state_next.rdSt = RD_BURST;
                        state_next.stbOe = 1'b1;
                        state_next.stbOut = 1'b0;
                        state_next.datOe = 1'b1;
                        state_next.rdCnt = '0;
                    end
                end
            end
            RD_BURST: begin
                if (rise || fall) begin
                    if (state_reg.rdCnt == blBeats) begin
                        state_next.rdSt = RD_IDLE;
                        state_next.stbOe = 1'b0;
                        state_next.datOe = 1'b0;
                        if (state_reg.rdAuto) begin
                            state_next.open[state_reg.rdBank] = 1'b0;
                        end
                    end else begin
                        // Both lanes carry the beat; mask pins are not looked at.
                        state_next.datOut = mem[rdAddr];
                        state_next.stbOut = ~state_reg.stbOut;
                        state_next.rdCnt = state_reg.rdCnt + BEAT_W'(1);
                    end
                end
            end
            default: begin
                state_next.rdSt = RD_IDLE;
            end
        endcase

        for (int l = 0; l < LANES; l++) begin
            if (state_reg.wrOn && state_reg.s2.stb[l] != state_reg.stbPrev[l]
                && state_reg.wrCnt[l] != blBeats) begin
                wrAddr[l] = {state_reg.wrBank, state_reg.wrRow,
                    dps_burst_col(state_reg.wrCol, state_reg.wrCnt[l], state_reg.blCode)};
                wrLaneEn[l] = ~state_reg.s2.mask[l];
                state_next.wrCnt[l] = state_reg.wrCnt[l] + BEAT_W'(1);
            end
        end
        if (state_reg.wrOn && state_next.wrCnt[0] == blBeats
            && state_next.wrCnt[1] == blBeats) begin
            state_next.wrOn = 1'b0;
            if (state_reg.wrAuto) begin
                state_next.open[state_reg.wrBank] = 1'b0;
            end
        end

        if (cmdOk) begin
            case (state_reg.s2.cmd)
                CMD_ACT: begin
                    state_next.open[bank] = 1'b1;
                    state_next.rows[bank] = state_reg.s2.addr;
                end
                CMD_READ: begin
                    if (state_reg.open[bank] && !busy) begin
                        state_next.rdSt = RD_WAIT;
                        state_next.rdWait = 8'(RD_LAT);
                        state_next.rdBank = bank;
                        state_next.rdRow = state_reg.rows[bank];
                        state_next.rdCol = state_reg.s2.addr[COL_W-1:0];
                        state_next.rdAuto = state_reg.s2.addr[AUTO_PRE_BIT];
                        state_next.rdCnt = '0;
                    end
                end
                CMD_WRITE: begin
                    if (state_reg.open[bank] && !busy) begin
                        state_next.wrOn = 1'b1;
                        state_next.wrBank = bank;
                        state_next.wrRow = state_reg.rows[bank];
                        state_next.wrCol = state_reg.s2.addr[COL_W-1:0];
                        state_next.wrAuto = state_reg.s2.addr[AUTO_PRE_BIT];
                        state_next.wrCnt = '0;
                    end
                end
                CMD_PRE: begin
                    if (state_reg.s2.addr[AUTO_PRE_BIT]) begin
                        state_next.open = '0;
                    end else begin
                        state_next.open[bank] = 1'b0;
                    end
                end
                CMD_REF: begin
                    if (state_reg.open == '0 && !busy) begin
                        state_next.refRow = state_reg.refRow + ROW_W'(1);
                    end
                end
                CMD_MRS: begin
                    if (!busy && bank == '0
                        && dps_bl_beats(state_reg.s2.addr[BL_LSB+:3]) != '0) begin
                        state_next.blCode = state_reg.s2.addr[BL_LSB+:3];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
            state_reg.blCode <= BL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // The array has no reset; contents are undefined until written.
    always_ff @(posedge clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (wrLaneEn[l]) begin
                mem[wrAddr[l]][l*8 +: 8] <= state_reg.s2.dat[l*8 +: 8];
            end
        end
    end

    assign link.dataDev = state_reg.datOut;
    assign link.dataDevOe = state_reg.datOe;
    assign link.strobeDev = {LANES{state_reg.stbOut}};
    assign link.strobeDevOe = state_reg.stbOe;
    assign devMode = state_reg.mode;
    assign bankOpen = state_reg.open;
    assign refreshRow = state_reg.refRow;
endmodule
`default_nettype wire

//--- verilog/dps_controller.sv
// Controller end: makes the link clock, issues commands and moves burst data.
`default_nettype none
module dps_controller #(
    parameter int HALF_CYC = dps_pkg::LINK_HALF_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    dps_link_if.ctl link,
    input wire logic cmdValid,
    input wire dps_pkg::dps_op_e cmdOp,
    input wire logic [dps_pkg::BANK_W-1:0] cmdBank,
    input wire logic [dps_pkg::ADDR_W-1:0] cmdAddr,
    output logic cmdReady,
    input wire logic lowPower,
    input wire logic [dps_pkg::DAT_W-1:0] wrBeatData,
    input wire logic [dps_pkg::LANES-1:0] wrBeatMask,
    output logic wrBeatTake,
    output logic [dps_pkg::DAT_W-1:0] rdBeatData,
    output logic rdBeatValid
);
    import dps_pkg::*;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_WPRE = 2'b01,
        C_WBURST = 2'b10,
        C_READ = 2'b11
    } dps_ctl_e;

    typedef struct packed {
        logic [7:0] phase;
        logic linkClk;
        logic linkClkN;
        logic gate;
        logic gateOk;
        logic [3:0] pins;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [2:0] blCode;
        dps_ctl_e st;
        logic [BEAT_W-1:0] cnt;
        logic [DAT_W-1:0] datOut;
        logic datOe;
        logic stbOut;
        logic stbOe;
        logic [LANES-1:0] mask;
        logic [LANES+DAT_W-1:0] rx1;
        logic [LANES+DAT_W-1:0] rx2;
        logic [LANES-1:0] stbPrev;
        logic [7:0] rdLo;
        logic ready;
        logic take;
        logic [DAT_W-1:0] rdData;
        logic rdValid;
        logic sref;
        logic [15:0] pdCnt;
    } dps_ctl_s;

    dps_ctl_s state_reg;
    dps_ctl_s state_next;
    logic wrap;
    logic rise;
    logic fall;
    logic [BEAT_W-1:0] blBeats;
    logic [LANES-1:0] stbEdge;

    always_comb begin
        state_next = state_reg;
        wrap = state_reg.phase == 8'(HALF_CYC - 1);
        rise = wrap & ~state_reg.linkClk;
        fall = wrap & state_reg.linkClk;
        blBeats = dps_bl_beats(state_reg.blCode);
        state_next.phase = wrap ? 8'h00 : state_reg.phase + 8'h01;
        if (wrap) begin
            state_next.linkClk = ~state_reg.linkClk;
            state_next.linkClkN = state_reg.linkClk;
        end
        state_next.ready = 1'b0;
        state_next.take = 1'b0;
        state_next.rdValid = 1'b0;
        state_next.sref = state_reg.sref & ~state_reg.gate;
        state_next.pdCnt = (state_reg.gate || state_reg.sref) ? 16'h0000
            : state_reg.pdCnt + 16'h0001;
        state_next.rx1 = {link.strobe_hi, link.strobe_lo, link.data_lines};
        state_next.rx2 = state_reg.rx1;
        state_next.stbPrev = state_reg.rx2[DAT_W +: LANES];
        stbEdge = state_reg.rx2[DAT_W +: LANES] ^ state_reg.stbPrev;

        if (rise) begin
            state_next.gateOk = state_reg.gate;
        end

        if (fall) begin
            state_next.pins = PINS_IDLE;
            // Gate goes low only between bursts, so power down starts from idle or active.
            // Power down has no refresh, so the gate is lifted before one falls due.
            state_next.gate = ~(lowPower && state_reg.st == C_IDLE)
                || state_reg.pdCnt >= 16'(SREF_INT_CYC - 4 * HALF_CYC);
            if (state_reg.st == C_IDLE && cmdValid && state_reg.gate && state_reg.gateOk
                && (cmdOp == OP_SREF || !lowPower)) begin
                state_next.pins = dps_op_pins(cmdOp);
                state_next.bank = cmdBank;
                state_next.addr = cmdAddr;
                state_next.ready = 1'b1;
                case (cmdOp)
                    OP_SREF: begin
                        state_next.gate = 1'b0;
                        state_next.sref = 1'b1;
                    end
                    OP_WRITE: state_next.st = C_WPRE;
                    OP_READ: begin
                        state_next.st = C_READ;
                        state_next.cnt = '0;
                    end
                    OP_MRS: begin
                        if (dps_bl_beats(cmdAddr[BL_LSB+:3]) != '0) begin
                            state_next.blCode = cmdAddr[BL_LSB+:3];
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (state_reg.st == C_WPRE) begin
                state_next.stbOe = 1'b1;
                state_next.stbOut = 1'b0;
                state_next.datOe = 1'b1;
                state_next.cnt = '0;
                state_next.st = C_WBURST;
            end
        end

        if (state_reg.st == C_WBURST && (rise || fall)) begin
            if (state_reg.cnt == blBeats) begin
                state_next.stbOe = 1'b0;
                state_next.datOe = 1'b0;
                state_next.st = C_IDLE;
            end else begin
                state_next.datOut = wrBeatData;
                state_next.mask = wrBeatMask;
                state_next.stbOut = ~state_reg.stbOut;
                state_next.take = 1'b1;
                state_next.cnt = state_reg.cnt + BEAT_W'(1);
            end
        end

        if (state_reg.st == C_READ) begin
            if (stbEdge[0]) begin
                state_next.rdLo = state_reg.rx2[7:0];
            end
            if (stbEdge[1]) begin
                state_next.rdData = {state_reg.rx2[15:8],
                    stbEdge[0] ? state_reg.rx2[7:0] : state_reg.rdLo};
                state_next.rdValid = 1'b1;
                state_next.cnt = state_reg.cnt + BEAT_W'(1);
                if (state_reg.cnt + BEAT_W'(1) == blBeats) begin
                    state_next.st = C_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
            state_reg.linkClkN <= 1'b1;
            state_reg.pins <= PINS_IDLE;
            state_reg.blCode <= BL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.diff_clk_pos = state_reg.linkClk;
    assign link.diff_clk_neg = state_reg.linkClkN;
    assign link.clk_gate_in = state_reg.gate;
    assign {link.chip_sel_n, link.row_strobe_n, link.col_strobe_n, link.write_strobe_n} =
        state_reg.pins;
    assign {link.bank_sel_1, link.bank_sel_0} = state_reg.bank;
    assign link.addr_bus = state_reg.addr;
    assign {link.wr_mask_hi, link.wr_mask_lo} = state_reg.mask;
    assign link.dataCtl = state_reg.datOut;
    assign link.dataCtlOe = state_reg.datOe;
    assign link.strobeCtl = {LANES{state_reg.stbOut}};
    assign link.strobeCtlOe = state_reg.stbOe;
    assign cmdReady = state_reg.ready;
    assign wrBeatTake = state_reg.take;
    assign rdBeatData = state_reg.rdData;
    assign rdBeatValid = state_reg.rdValid;
endmodule
`default_nettype wire

//--- test/dps_link_checker.sv
// Timing and ownership checks on the pins between the two link ends.
`default_nettype none
module dps_link_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic diff_clk_pos,
    input wire logic diff_clk_neg,
    input wire logic clk_gate_in,
    input wire logic chip_sel_n,
    input wire logic write_strobe_n,
    input wire logic dataDevOe,
    input wire logic dataCtlOe,
    input wire logic [dps_pkg::LANES-1:0] strobeDev,
    input wire logic strobeDevOe,
    input wire logic [dps_pkg::LANES-1:0] strobeCtl,
    input wire logic strobeCtlOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_clk_pair: assert property (diff_clk_neg == !diff_clk_pos)
        else $error("link clock halves differ");
    a_cmd_setup: assert property ($changed(chip_sel_n) |-> $fell(diff_clk_pos))
        else $error("command moved off the link fall");
    a_gate_edge: assert property ($changed(clk_gate_in) |-> $fell(diff_clk_pos))
        else $error("clock gate moved off the link fall");
    a_gate_first: assert property (!chip_sel_n && !write_strobe_n |-> clk_gate_in)
        else $error("command issued with gate low");
    a_data_owner: assert property (!(dataDevOe && dataCtlOe))
        else $error("both ends drive data");
    a_strobe_owner: assert property (!(strobeDevOe && strobeCtlOe))
        else $error("both ends drive strobe");
    a_wr_preamble: assert property ($rose(strobeCtlOe) |->
        (strobeCtl == 2'h0 && dataCtlOe) [*4] ##1 strobeCtl == 2'h3)
        else $error("write strobe preamble wrong");
    a_rd_preamble: assert property ($rose(strobeDevOe) |->
        (strobeDev == 2'h0) [*4] ##1 strobeDev == 2'h3)
        else $error("read strobe preamble wrong");
endmodule
`default_nettype wire

//--- test/dps_bench.sv
// Bench joining controller and device across the link.
`default_nettype none
module dps_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dps_pkg::*;
    typedef struct {dps_op_e op; logic [1:0] bk; logic [11:0] ad; logic [3:0] open;} dps_row_s;
    logic clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0, lowPower = 1'b0;
    dps_op_e cmdOp = OP_NOP;
    logic [1:0] cmdBank = 2'h0, wrBeatMask = 2'h0, devMode;
    logic [11:0] cmdAddr = 12'h000, refreshRow;
    logic [15:0] wrBeatData = 16'h1A1A, rdBeatData, rdQ[$];
    logic [3:0] bankOpen;
    logic cmdReady, wrBeatTake, rdBeatValid;
    int error_cnt = 0, checks_done = 0, wIdx = 0;
    // The eighth beat leaves both mask pins high through the read.
    logic [15:0] wData[9] = '{16'h1A1A, 16'h2B2B, 16'h3C3C, 16'h4D4D, 16'h5E5E, 16'h6F6F,
        16'h7A7A, 16'h8B8B, 16'h0000};
    logic [1:0] wMask[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [15:0] rdExp[4] = '{16'h5E5E, 16'h6F2B, 16'h3C7A, 16'h4D4D};
    dps_row_s rows[11] = '{'{OP_MRS, 2'h0, 12'h002, 4'h0}, '{OP_ACT, 2'h0, 12'h001, 4'h1},
        '{OP_ACT, 2'h1, 12'h002, 4'h3}, '{OP_ACT, 2'h2, 12'h003, 4'h7},
        '{OP_ACT, 2'h3, 12'h004, 4'hF}, '{OP_PRE, 2'h1, 12'h000, 4'hD},
        '{OP_WRITE, 2'h2, 12'h010, 4'hD}, '{OP_WRITE, 2'h2, 12'h010, 4'hD},
        '{OP_READ, 2'h2, 12'h410, 4'h9}, '{OP_PRE, 2'h0, 12'h400, 4'h0},
        '{OP_REF, 2'h0, 12'h000, 4'h0}};
    dps_link_if link ();
    dps_device #(.SREF_INT(16)) dps_device_inst (.clk(clk), .arst_n(arst_n), .link(link.dev),
        .devMode(devMode), .bankOpen(bankOpen), .refreshRow(refreshRow));
    dps_controller dps_controller_inst (.clk(clk), .arst_n(arst_n), .link(link.ctl),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdBank(cmdBank), .cmdAddr(cmdAddr),
        .cmdReady(cmdReady), .lowPower(lowPower), .wrBeatData(wrBeatData),
        .wrBeatMask(wrBeatMask), .wrBeatTake(wrBeatTake), .rdBeatData(rdBeatData),
        .rdBeatValid(rdBeatValid));
    dps_link_checker dps_link_checker_inst (.clk(clk), .arst_n(arst_n),
        .diff_clk_pos(link.diff_clk_pos), .diff_clk_neg(link.diff_clk_neg),
        .clk_gate_in(link.clk_gate_in), .chip_sel_n(link.chip_sel_n),
        .write_strobe_n(link.write_strobe_n), .dataDevOe(link.dataDevOe),
        .dataCtlOe(link.dataCtlOe), .strobeDev(link.strobeDev), .strobeDevOe(link.strobeDevOe),
        .strobeCtl(link.strobeCtl), .strobeCtlOe(link.strobeCtlOe));
    task automatic cmp(input string name, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic issue(input dps_op_e op, input logic [1:0] bk, input logic [11:0] ad);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdBank <= bk;
        cmdAddr <= ad;
        repeat (300) begin
            @(posedge clk);
            if (cmdReady === 1'b1) break;
        end
        cmp("cmdReady", 16'h0001, 16'(cmdReady));
        cmdValid <= 1'b0;
    endtask
    task automatic settle(input logic [3:0] open, input logic [1:0] mode);
        repeat (200) begin
            @(posedge clk);
            if (bankOpen === open && devMode === mode) break;
        end
        cmp("bankOpen", 16'(open), 16'(bankOpen));
        cmp("devMode", 16'(mode), 16'(devMode));
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Next beat is staged the cycle after a take, well inside the half link period.
    always @(posedge clk) begin
        if (wrBeatTake === 1'b1) begin
            wIdx <= wIdx + 1;
            wrBeatData <= wData[wIdx + 1];
            wrBeatMask <= wMask[wIdx + 1];
        end
        if (rdBeatValid === 1'b1) rdQ.push_back(rdBeatData);
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        settle(4'h0, 2'h0);
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].bk, rows[i].ad);
            settle(rows[i].open, 2'h0);
        end
        cmp("readCount", 16'h0004, 16'(rdQ.size()));
        foreach (rdExp[i]) cmp("readBeat", rdExp[i], rdQ[i]);
        repeat (16) @(posedge clk);
        cmp("refreshRow", 16'h0001, 16'(refreshRow));
        lowPower <= 1'b1;
        issue(OP_SREF, 2'h0, 12'h000);
        settle(4'h0, 2'h2);
        repeat (20) @(posedge clk);
        cmp("refreshRow", 16'h0003, 16'(refreshRow));
        lowPower <= 1'b0;
        settle(4'h0, 2'h0);
        issue(OP_ACT, 2'h1, 12'h005);
        lowPower <= 1'b1;
        settle(4'h2, 2'h1);
        repeat (SREF_INT_CYC) begin
            @(posedge clk);
            if (devMode === 2'h0) break;
        end
        cmp("devMode", 16'h0000, 16'(devMode));
        lowPower <= 1'b0;
        settle(4'h2, 2'h0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        settle(4'h0, 2'h0);
        cmp("refreshRow", 16'h0000, 16'(refreshRow));
        results();
    end
endmodule
`default_nettype wire
